/* adc_conv_model.sv */
// Behavioural converter that answers the serial host
`timescale 1ns/1ns

module adc_conv_model
(
    // Pins shared with the host; the converter never makes a clock
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    output logic             serial_result_out_o,
    // Stimulus and observation
    input  wire logic [11:0] sample_i,
    output logic             powered_o,
    output logic [4:0]       falls_o,
    output logic [14:0]      hist_o,
    output logic             quiet_err_o
);
    // Float time plus quiet interval
    localparam int QUIET_NS = 95;
    logic [15:0] word;
    logic [4:0]  cnt;
    time         t_rise;

    initial
    begin
        serial_result_out_o = 1'b0;
        powered_o = 1'b0;
        falls_o = 5'h00;
        hist_o = 15'h0000;
        quiet_err_o = 1'b0;
        cnt = 5'h00;
        word = 16'h0000;
        t_rise = 0;
    end

    always @(negedge cs_n_i)
    begin
        if ($time - t_rise < QUIET_NS)
            quiet_err_o = 1'b1;
        cnt = 5'h00;
        word = {4'h0, sample_i};
        serial_result_out_o = word[15];
    end

    always @(negedge sclk_i)
        if (cs_n_i == 1'b0)
            cnt = cnt + 5'h01;

    // New bit on the rising clock so the host's sampler sees it settled; no stale bit once released
    always @(posedge sclk_i)
        if (cs_n_i == 1'b0 && cnt < 5'h10)
            serial_result_out_o = word[15 - cnt];

    always @(posedge cs_n_i)
    begin
        t_rise = $time;
        serial_result_out_o = ~serial_result_out_o;
        if (cnt >= 5'h0A)
            powered_o = 1'b1;
        else if (cnt >= 5'h02)
            powered_o = 1'b0;
        falls_o = cnt;
        hist_o = {hist_o[9:0], cnt};
    end
endmodule

/* adc_host_defs.svh */
// Timing and framing constants for the converter serial host
`ifndef ADC_HOST_DEFS_SVH
`define ADC_HOST_DEFS_SVH
// Notes on behaviour
// R1 - Conversion and readback use sixteen-clock frames
// R2 - Eight-clock burst puts converter into power-down
// R3 - Frame is active low, once per word
// R4 - Every word gets its own fresh frame
// R5 - Host generates the serial clock as master
// R6 - Outgoing frame also gates the receive path
// R7 - Received word is right-justified, result low
// R8 - Frame starts spaced by whole clock periods
// R9 - Power-down mode: dummy frame, then conversion
// R10 - Dummy frame may end after tenth fall
// R11 - Lower serial clock above 320 kSPS
// R12 - Ten falls held low keep converter powered
// R13 - Release between falls two and ten powers down; host clears powered only from three falls
// R14 - Sixteen falls complete conversion; earlier aborts it
// R15 - Quiet interval before next frame start
// R16 - Word length chosen per frame, sixteen or eight; the code also has the ten-clock short dummy frame

// Host system clock rate
`define SYS_CLK_MHZ      20
// Output float time after frame release, and quiet interval, in ns
`define TRISTATE_NS      35
`define QUIET_INTERVAL_NS 60
// Cycles of frame-high time before the next frame, rounded up
`define QUIET_CYC        (((`TRISTATE_NS + `QUIET_INTERVAL_NS) * `SYS_CLK_MHZ + 999) / 1000)

// Falling serial clock edges per frame kind, and the powered and power-down thresholds
`define CONV_FALLS       5'h10
`define BURST_FALLS      5'h08
`define DUMMY_FALLS      5'h0A
`define POWERED_FALLS    5'h0A
`define PD_MIN_FALLS     5'h02

// System clocks per serial clock half period, default sample period
`define SCLK_HALF_DEF    4
`define PERIOD_DEF       16'h0020
`define RESULT_BITS      12
`define WORD_BITS        16

`endif

/* adc_host_framing.sv */
// Serial host that frames conversions for a chip-select converter
`timescale 1ns/1ns
`include "adc_host_defs.svh"

module adc_host_framing
    import adc_host_pkg::*;
#(
    // Lower rate trades throughput for converter power at high sample rates
    parameter int SCLK_HALF = `SCLK_HALF_DEF // R11
)
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    // Single frame requests
    input  wire logic        frame_req_i,
    input  frame_kind_e      frame_kind_i,
    output logic             frame_ready_o,
    // Equidistant automatic sampling
    input  wire logic        auto_en_i,
    input  wire logic        auto_pd_i,
    input  wire logic [15:0] auto_period_i,
    // Results and status
    output logic [11:0]      result_o,
    output logic             result_valid_o,
    output logic             powered_o,
    output logic             busy_o,
    output logic             overrun_o,
    // Converter pins
    output logic             sclk_o,
    output logic             host_transmit_frame_n_o,
    input  wire logic        serial_result_out_i
);

    localparam int         DIVW      = $clog2(SCLK_HALF + 1);
    localparam logic [3:0] QUIET_CYC = 4'(`QUIET_CYC);
    localparam int         SEQ_MAX   = `QUIET_CYC + 4 * SCLK_HALF + 4;

    // Serial clock divider; idles high, frames start on rising ticks
    logic [DIVW-1:0] div_cnt;
    logic [DIVW-1:0] next_div_cnt;
    logic            sclk_ph;
    logic            next_sclk_ph;
    logic            half_tick;
    logic            period_tick;

    always_comb
    begin
        half_tick    = (div_cnt == DIVW'(SCLK_HALF - 1));
        period_tick  = half_tick && !sclk_ph;
        next_div_cnt = half_tick ? '0 : DIVW'(div_cnt + 1'b1);
        next_sclk_ph = half_tick ? !sclk_ph : sclk_ph; // R5
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            div_cnt <= '0;
            sclk_ph <= 1'b1;
        end
        else
        begin
            div_cnt <= next_div_cnt;
            sclk_ph <= next_sclk_ph;
        end
    end

    // Two-stage synchroniser on the returned serial data
    logic sd_meta;
    logic sd_sync;
    logic next_sd_meta;
    logic next_sd_sync;

    always_comb
    begin
        next_sd_meta = serial_result_out_i;
        next_sd_sync = sd_meta;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            sd_meta <= 1'b0;
            sd_sync <= 1'b0;
        end
        else
        begin
            sd_meta <= next_sd_meta;
            sd_sync <= next_sd_sync;
        end
    end

    // Frame engine
    frame_state_e state;
    frame_state_e next_state;
    fall_cnt_t    fall_cnt;
    fall_cnt_t    next_fall_cnt;
    fall_cnt_t    cur_len;
    fall_cnt_t    next_cur_len;
    frame_kind_e  cur_kind;
    frame_kind_e  next_cur_kind;
    logic [15:0]  shift;
    logic [15:0]  next_shift;
    logic [3:0]   quiet_cnt;
    logic [3:0]   next_quiet_cnt;
    logic         cs_n;
    logic         next_cs_n;
    logic         sclk_q;
    logic         next_sclk_q;
    logic [11:0]  result;
    logic [11:0]  next_result;
    logic         res_vld;
    logic         next_res_vld;
    logic         powered;
    logic         next_powered;
    logic         host_receive_frame;
    logic         frame_start;
    logic         frame_done;

    // Sequencer state; the frame engine reads pend_valid and pend_kind
    logic         pend_valid;
    logic         next_pend_valid;
    frame_kind_e  pend_kind;
    frame_kind_e  next_pend_kind;
    seq_step_e    seq_step;
    seq_step_e    next_seq_step;
    logic [15:0]  period_cnt;
    logic [15:0]  next_period_cnt;
    logic         ovr;
    logic         next_ovr;

    function automatic fall_cnt_t kind_len(input frame_kind_e k);
        fall_cnt_t len;
        case (k)
            KIND_CONV:       len = `CONV_FALLS;  // R1
            KIND_BURST:      len = `BURST_FALLS; // R2
            KIND_DUMMY:      len = `DUMMY_FALLS; // R10
            KIND_DUMMY_FULL: len = `CONV_FALLS;
            default:         len = `CONV_FALLS;
        endcase
        return len;
    endfunction

    always_comb
    begin
        host_receive_frame = !cs_n; // R6
        frame_start        = (state == ST_IDLE) && period_tick && pend_valid; // R8
        frame_done         = (state == ST_RUN) && period_tick && (fall_cnt == cur_len);
        next_state     = state;
        next_fall_cnt  = fall_cnt;
        next_cur_len   = cur_len;
        next_cur_kind  = cur_kind;
        next_shift     = shift;
        next_quiet_cnt = quiet_cnt;
        next_cs_n      = cs_n;
        next_sclk_q    = sclk_q;
        next_result    = result;
        next_res_vld   = 1'b0;
        next_powered   = powered;
        case (state)
            ST_IDLE:
            begin
                next_sclk_q = 1'b1;
                if (frame_start)
                begin
                    next_state    = ST_RUN;
                    next_cs_n     = 1'b0; // R3
                    next_fall_cnt = '0;
                    next_cur_kind = pend_kind;
                    next_cur_len  = kind_len(pend_kind); // R16
                    next_shift    = '0;
                end
            end
            ST_RUN:
            begin
                next_sclk_q = next_sclk_ph; // R5
                if (half_tick && sclk_ph && host_receive_frame)
                begin
                    // Data settles a half period before the fall; two cycles go to the synchroniser
                    next_shift    = {shift[14:0], sd_sync}; // R6
                    next_fall_cnt = fall_cnt_t'(fall_cnt + 1'b1);
                end
                if (frame_done)
                begin
                    next_state     = ST_QUIET;
                    next_cs_n      = 1'b1; // R4
                    next_sclk_q    = 1'b1;
                    next_quiet_cnt = '0;
                    if (fall_cnt >= `POWERED_FALLS)
                    begin
                        next_powered = 1'b1; // R12
                    end
                    else if (fall_cnt > `PD_MIN_FALLS)
                    begin
                        next_powered = 1'b0; // R13
                    end
                    if (cur_kind == KIND_CONV)
                    begin
                        next_result  = shift[`RESULT_BITS-1:0]; // R7
                        next_res_vld = 1'b1; // R14
                    end
                end
            end
            ST_QUIET:
            begin
                next_sclk_q    = 1'b1;
                next_quiet_cnt = 4'(quiet_cnt + 1'b1);
                if (quiet_cnt >= QUIET_CYC - 4'h1)
                begin
                    next_state = ST_IDLE; // R15
                end
            end
            default:
            begin
                next_state  = ST_IDLE;
                next_cs_n   = 1'b1;
                next_sclk_q = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            state     <= ST_IDLE;
            fall_cnt  <= '0;
            cur_len   <= `CONV_FALLS;
            cur_kind  <= KIND_CONV;
            shift     <= 16'h0000;
            quiet_cnt <= 4'h0;
            cs_n      <= 1'b1;
            sclk_q    <= 1'b1;
            result    <= 12'h000;
            res_vld   <= 1'b0;
            powered   <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            fall_cnt  <= next_fall_cnt;
            cur_len   <= next_cur_len;
            cur_kind  <= next_cur_kind;
            shift     <= next_shift;
            quiet_cnt <= next_quiet_cnt;
            cs_n      <= next_cs_n;
            sclk_q    <= next_sclk_q;
            result    <= next_result;
            res_vld   <= next_res_vld;
            powered   <= next_powered;
        end
    end

    // Request sequencer; an automatic tick while still busy is dropped, not queued
    logic period_hit;
    logic fire;
    logic seq_busy;

    always_comb
    begin
        period_hit      = (17'(period_cnt) + 17'h00001) >= 17'(auto_period_i);
        fire            = auto_en_i && period_tick && period_hit; // R8
        seq_busy        = pend_valid || (state != ST_IDLE) || (seq_step != SEQ_NONE);
        frame_ready_o   = !auto_en_i && !pend_valid;
        next_pend_valid = pend_valid;
        next_pend_kind  = pend_kind;
        next_seq_step   = seq_step;
        next_ovr        = 1'b0;
        next_period_cnt = period_cnt;
        if (!auto_en_i)
        begin
            next_period_cnt = 16'h0000;
        end
        else if (period_tick)
        begin
            next_period_cnt = period_hit ? 16'h0000 : 16'(period_cnt + 1'b1);
        end
        if (frame_start)
        begin
            next_pend_valid = 1'b0;
        end
        if (frame_req_i && frame_ready_o)
        begin
            next_pend_valid = 1'b1;
            next_pend_kind  = frame_kind_i; // R16
        end
        if (fire)
        begin
            if (seq_busy)
            begin
                next_ovr = 1'b1;
            end
            else if (auto_pd_i)
            begin
                next_pend_valid = 1'b1;
                next_pend_kind  = KIND_DUMMY; // R9
                next_seq_step   = SEQ_DUMMY;
            end
            else
            begin
                next_pend_valid = 1'b1;
                next_pend_kind  = KIND_CONV;
            end
        end
        if (frame_done)
        begin
            case (seq_step)
                SEQ_DUMMY:
                begin
                    next_pend_valid = 1'b1;
                    next_pend_kind  = KIND_CONV; // R9
                    next_seq_step   = SEQ_CONV;
                end
                SEQ_CONV:
                begin
                    next_pend_valid = 1'b1;
                    next_pend_kind  = KIND_BURST; // R2
                    next_seq_step   = SEQ_DOWN;
                end
                SEQ_DOWN:
                begin
                    next_seq_step = SEQ_NONE;
                end
                default:
                begin
                    next_seq_step = SEQ_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            pend_valid <= 1'b0;
            pend_kind  <= KIND_CONV;
            seq_step   <= SEQ_NONE;
            period_cnt <= 16'h0000;
            ovr        <= 1'b0;
        end
        else
        begin
            pend_valid <= next_pend_valid;
            pend_kind  <= next_pend_kind;
            seq_step   <= next_seq_step;
            period_cnt <= next_period_cnt;
            ovr        <= next_ovr;
        end
    end

    assign sclk_o                  = sclk_q;
    assign host_transmit_frame_n_o = cs_n;
    assign result_o                = result;
    assign result_valid_o          = res_vld;
    assign powered_o               = powered;
    assign overrun_o               = ovr;
    assign busy_o                  = (state != ST_IDLE) || pend_valid;

    // Pin-level observers for the checks below
    logic      sclk_d;
    fall_cnt_t pin_falls;
    logic [3:0] cs_hi_cnt;

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            sclk_d    <= 1'b1;
            pin_falls <= '0;
            cs_hi_cnt <= 4'hF;
        end
        else
        begin
            sclk_d    <= sclk_o;
            pin_falls <= host_transmit_frame_n_o ? fall_cnt_t'(0) :
                         (sclk_d && !sclk_o) ? fall_cnt_t'(pin_falls + 1'b1) : pin_falls;
            cs_hi_cnt <= !host_transmit_frame_n_o ? 4'h0 :
                         (cs_hi_cnt == 4'hF) ? cs_hi_cnt : 4'(cs_hi_cnt + 1'b1);
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    AST_CONV_LEN: assert property ($rose(host_transmit_frame_n_o) && cur_kind == KIND_CONV |-> // R1
                                   pin_falls == 5'h10)
        else $error("conversion frame not sixteen clocks");
    AST_BURST_LEN: assert property ($rose(host_transmit_frame_n_o) && cur_kind == KIND_BURST |-> // R2
                                    pin_falls == 5'h08)
        else $error("power-down burst not eight clocks");
    AST_FRAME_LOW: assert property ($fell(host_transmit_frame_n_o) |-> sclk_o ##1 !host_transmit_frame_n_o) // R3
        else $error("frame fall malformed");
    AST_FRESH_WORD: assert property (!host_transmit_frame_n_o |-> pin_falls <= 5'h10) // R4
        else $error("frame spans more than one word");
    AST_CLK_IDLE: assert property (host_transmit_frame_n_o |-> sclk_o) // R5
        else $error("serial clock toggles outside a frame");
    // The clear at frame start lands with the frame already low, so check the current level
    AST_RX_GATE: assert property ($changed(shift) |-> host_receive_frame) // R6
        else $error("receive capture outside frame");
    AST_RESULT: assert property (result_valid_o |-> $rose(host_transmit_frame_n_o) && $past(pin_falls) == 5'h10) // R7
        else $error("result without full sixteen-clock word");
    AST_ALIGN: assert property ($fell(host_transmit_frame_n_o) |-> $past(period_tick)) // R8
        else $error("frame start off serial clock period");
    AST_SEQ: assert property ($rose(host_transmit_frame_n_o) && cur_kind == KIND_DUMMY && // R9
                              seq_step == SEQ_CONV |->
                              ##[1:SEQ_MAX] ($fell(host_transmit_frame_n_o) && cur_kind == KIND_CONV))
        else $error("dummy frame not followed by conversion");
    AST_DUMMY_LEN: assert property ($rose(host_transmit_frame_n_o) && cur_kind == KIND_DUMMY |-> // R10
                                    pin_falls == 5'h0A)
        else $error("short dummy frame not ten clocks");
    AST_POWERED: assert property ($rose(host_transmit_frame_n_o) && pin_falls >= 5'h0A |-> powered_o) // R12
        else $error("powered flag lost after long frame");
    AST_PD: assert property ($rose(host_transmit_frame_n_o) && pin_falls == 5'h08 |-> !powered_o) // R13
        else $error("powered flag kept after burst");
    AST_ABORT: assert property ($rose(host_transmit_frame_n_o) && pin_falls < 5'h10 |-> !result_valid_o) // R14
        else $error("result from aborted conversion");
    AST_QUIET: assert property ($fell(host_transmit_frame_n_o) |-> cs_hi_cnt >= QUIET_CYC) // R15
        else $error("quiet interval violated");
    AST_LEN_SET: assert property ($rose(host_transmit_frame_n_o) |-> // R16
                                  pin_falls == 5'h08 || pin_falls == 5'h0A || pin_falls == 5'h10)
        else $error("frame length not a legal setting");

endmodule

/* adc_host_pkg.sv */
// Types for the converter serial host
package adc_host_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_RUN   = 2'b01,
        ST_QUIET = 2'b11
    } frame_state_e;

    typedef enum logic [1:0]
    {
        KIND_CONV       = 2'b00,
        KIND_BURST      = 2'b01,
        KIND_DUMMY      = 2'b10,
        KIND_DUMMY_FULL = 2'b11
    } frame_kind_e;

    typedef enum logic [1:0]
    {
        SEQ_NONE  = 2'b00,
        SEQ_DUMMY = 2'b01,
        SEQ_CONV  = 2'b11,
        SEQ_DOWN  = 2'b10
    } seq_step_e;

    typedef logic [4:0] fall_cnt_t;

endpackage

/* tb_adc_host_framing.sv */
// Self-checking bench for the converter serial host
`timescale 1ns/1ns

module tb_adc_host_framing
    import adc_host_pkg::*;
;
    localparam int HALF = 4;
    logic        clk_sys_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        frame_req_i = 1'b0;
    frame_kind_e frame_kind_i = KIND_CONV;
    logic        auto_en_i = 1'b0;
    logic        auto_pd_i = 1'b0;
    logic [15:0] auto_period_i = 16'h0000;
    logic [11:0] sample = 12'h000;
    logic        frame_ready_o;
    logic [11:0] result_o;
    logic        result_valid_o;
    logic        powered_o;
    logic        busy_o;
    logic        overrun_o;
    logic        sclk_o;
    logic        host_transmit_frame_n_o;
    logic        serial_result_out;
    logic        adc_pw;
    logic [4:0]  adc_falls;
    logic [14:0] adc_hist;
    logic        adc_qerr;
    int          n_fail = 0;
    int          compares = 0;
    int          cyc = 0;

    adc_host_framing #(.SCLK_HALF(HALF)) i_dut
    (
        .clk_sys_i               (clk_sys_i),
        .nrst_i                  (nrst_i),
        .frame_req_i             (frame_req_i),
        .frame_kind_i            (frame_kind_i),
        .frame_ready_o           (frame_ready_o),
        .auto_en_i               (auto_en_i),
        .auto_pd_i               (auto_pd_i),
        .auto_period_i           (auto_period_i),
        .result_o                (result_o),
        .result_valid_o          (result_valid_o),
        .powered_o               (powered_o),
        .busy_o                  (busy_o),
        .overrun_o               (overrun_o),
        .sclk_o                  (sclk_o),
        .host_transmit_frame_n_o (host_transmit_frame_n_o),
        .serial_result_out_i     (serial_result_out)
    );

    adc_conv_model i_adc
    (
        .sclk_i      (sclk_o),
        .cs_n_i      (host_transmit_frame_n_o),
        .serial_result_out_o     (serial_result_out),
        .sample_i    (sample),
        .powered_o   (adc_pw),
        .falls_o     (adc_falls),
        .hist_o      (adc_hist),
        .quiet_err_o (adc_qerr)
    );

    always #25 clk_sys_i = ~clk_sys_i;

    task automatic test_done();
        if (n_fail == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Runs are a few thousand cycles; this only cuts a hang short
    always @(posedge clk_sys_i)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wait_cs(input logic lvl, output int n);
        n = 0;
        while (host_transmit_frame_n_o !== lvl && n < 4000)
        begin
            tick();
            n++;
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 4000)
        begin
            tick();
            n++;
        end
    endtask

    task automatic run_frame(input frame_kind_e k, input logic [4:0] nf, input logic rv, input logic pw);
        int n;
        wait_idle();
        frame_kind_i = k;
        frame_req_i = 1'b1;
        tick();
        frame_req_i = 1'b0;
        wait_cs(1'b0, n);
        wait_cs(1'b1, n);
        chk(result_valid_o === rv, "result strobe");
        chk(adc_falls === nf, "clock falls in frame");
        chk(powered_o === pw && adc_pw === pw, "power state");
        if (rv)
            chk(result_o === sample, "result value");
    endtask

    task automatic back_to_back();
        int n;
        int pulses;
        pulses = 0;
        wait_idle();
        sample = 12'h3C7;
        frame_kind_i = KIND_CONV;
        frame_req_i = 1'b1;
        tick();
        frame_req_i = 1'b0;
        wait_cs(1'b0, n);
        chk(frame_ready_o === 1'b1, "second request not open");
        frame_req_i = 1'b1;
        tick();
        frame_req_i = 1'b0;
        for (n = 0; n < 800; n++)
        begin
            if (result_valid_o === 1'b1)
                pulses++;
            tick();
        end
        chk(pulses == 2 && adc_hist[9:0] === 10'h210, "one frame per word");
        chk(adc_qerr === 1'b0, "quiet time broken");
    endtask

    task automatic auto_run(input logic pd, input logic [15:0] per);
        int n;
        int gap;
        wait_idle();
        auto_pd_i = pd;
        auto_period_i = per;
        auto_en_i = 1'b1;
        tick();
        chk(frame_ready_o === 1'b0, "manual request open in auto");
        wait_cs(1'b0, n);
        if (pd)
        begin
            wait_cs(1'b1, gap);
            wait_cs(1'b0, gap);
            wait_cs(1'b1, gap);
            chk(result_valid_o === 1'b1 && result_o === sample, "result after dummy");
            wait_cs(1'b0, gap);
            wait_cs(1'b1, gap);
            chk(adc_hist === {5'h0A, 5'h10, 5'h08}, "power-down sequence");
            chk(powered_o === 1'b0 && adc_pw === 1'b0, "left powered");
        end
        else
        begin
            wait_cs(1'b1, gap);
            wait_cs(1'b0, n);
            chk(gap + n == int'(per) * 2 * HALF, "sample spacing");
            chk(adc_falls === 5'h10, "auto word length");
        end
        auto_en_i = 1'b0;
        wait_idle();
    endtask

    task automatic overrun_chk();
        int n;
        logic seen;
        seen = 1'b0;
        auto_pd_i = 1'b0;
        auto_period_i = 16'h0001;
        auto_en_i = 1'b1;
        for (n = 0; n < 400; n++)
        begin
            tick();
            seen = seen | (overrun_o === 1'b1);
        end
        chk(seen, "dropped period not flagged");
        auto_en_i = 1'b0;
        wait_idle();
    endtask

    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        nrst_i = 1'b1;
        chk(host_transmit_frame_n_o === 1'b1 && sclk_o === 1'b1, "idle levels");
        chk(powered_o === 1'b0 && busy_o === 1'b0, "reset state");
        run_frame(KIND_DUMMY, 5'h0A, 1'b0, 1'b1);
        sample = 12'hA5C;
        run_frame(KIND_CONV, 5'h10, 1'b1, 1'b1);
        run_frame(KIND_BURST, 5'h08, 1'b0, 1'b0);
        run_frame(KIND_DUMMY_FULL, 5'h10, 1'b0, 1'b1);
        back_to_back();
        auto_run(1'b0, 16'h0014);
        auto_run(1'b1, 16'h003C);
        overrun_chk();
        chk(adc_qerr === 1'b0, "quiet time broken");
        test_done();
    end
endmodule
